// ---- src/hprx_pkg.sv ----
// hprx_pkg: constants for the host port pin control block
// assumes a 250 MHz core clock; no bus, all controls are plain ports
package hprx_pkg;
	localparam int          NUM_CH          = 14;
	localparam int          DATA_W          = 8;
	localparam int          ADDR_W          = 11;
	localparam int          CASC_N          = 5;
	localparam int          CLK_PERIOD_PS   = 4000;
	// reset qualification: low for more than 10 us
	localparam int          RST_MIN_US      = 10;
	localparam int          RST_MIN_CYC     = (RST_MIN_US * 1000000) / CLK_PERIOD_PS + 1;
	localparam int          RST_CNT_W       = 12;
	// host type codes
	localparam logic [2:0]  HT_ASYNC_A      = 3'h0;
	localparam logic [2:0]  HT_ASYNC_B      = 3'h1;
	localparam logic [2:0]  HT_SYNC         = 3'h7;
	// upper address decode
	localparam int          SEL_MSB         = 10;
	localparam int          SEL_LSB         = 8;
	localparam logic [2:0]  SEL_SELF        = 3'h0;
	localparam logic [2:0]  SEL_RSVD        = 3'h6;
	localparam logic [2:0]  SEL_ALL         = 3'h7;
	// reset values
	localparam logic [13:0] RX_EN_RST       = 14'h0000;
	localparam logic [13:0] TERM_RST        = 14'h0000;
	localparam logic [4:0]  CASC_IDLE_N     = 5'h1f;
endpackage : hprx_pkg

// ---- src/hprx_casc_dec.sv ----
// hprx_casc_dec: decodes the upper address bits into cascade selects
// assumes a synchronous host address and chip select
`timescale 1ns/10ps
module hprx_casc_dec (
	// host address and select
	input  wire logic [2:0] i_upper,
	input  wire logic       i_cs_n,
	// decoded selects, active high
	output logic            o_self,
	output logic [4:0]      o_casc,
	output logic            o_rsvd
);
	// 000 self, 001..101 one output, 111 self and all five outputs, 110 only o_rsvd
	wire         all_w = (i_upper == hprx_pkg::SEL_ALL);
	wire  [4:0]  one_w = (i_upper >= 3'h1 && i_upper <= 3'h5) ?
		5'((5'h1 << (i_upper - 3'h1))) : 5'h00;
	assign o_self = !i_cs_n && (i_upper == hprx_pkg::SEL_SELF || all_w);
	assign o_casc = i_cs_n ? 5'h00 : (all_w ? 5'h1f : one_w);
	assign o_rsvd = !i_cs_n && (i_upper == hprx_pkg::SEL_RSVD);
endmodule : hprx_casc_dec

// ---- src/hprx_top.sv ----
// hprx_top: host port pin control; data bus pins, host type, reset
// qualification, cascade selects, receiver power and termination.
// assumes all inputs synchronous to i_clk; protocol engine is outside.
`timescale 1ns/10ps
module hprx_top (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// host pins
	input  wire logic [7:0]  i_data,
	input  wire logic [10:0] i_addr,
	input  wire logic        i_cs_n,
	input  wire logic [2:0]  i_host_type_select,
	input  wire logic        i_hw_reset_n,
	// access from the protocol engine
	input  wire logic        i_rd_active,
	input  wire logic        i_wr_strobe,
	input  wire logic [7:0]  i_rd_data,
	// register controls
	input  wire logic [13:0] i_rx_en_bits,
	input  wire logic [13:0] i_term_bits,
	input  wire logic        i_termination_source_select,
	// receiver pins
	input  wire logic        i_receiver_power_pin,
	input  wire logic        i_receive_termination_pin,
	// data bus drive, oe low while driving
	output logic [7:0]       o_data,
	output logic             o_data_oe_n,
	// captured write data
	output logic [7:0]       o_wr_data,
	output logic             o_wr_valid,
	// host type decode
	output logic [1:0]       o_host_mode,
	output logic             o_host_type_bad,
	// qualified reset, high while a long pin low holds
	output logic             o_reg_reset,
	// selects
	output logic             o_self_sel,
	output logic             o_cascade_select_out_1_n,
	output logic             o_cascade_select_out_2_n,
	output logic             o_cascade_select_out_3_n,
	output logic             o_cascade_select_out_4_n,
	output logic             o_cascade_select_out_5_n,
	// receiver controls
	output logic [13:0]      o_rx_power,
	output logic [13:0]      o_rx_term
);
	typedef enum logic [1:0] {HPRX_IDLE, HPRX_COUNT, HPRX_FIRED} hprx_rst_t;

	// reset release through two flops
	logic        rs1_q, rst_n_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rs1_q   <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rs1_q   <= 1'b1;
			rst_n_q <= rs1_q;
		end
	end

	// hardware reset pin qualification; short glitches are ignored
	hprx_rst_t             st_q, st_d;
	logic [11:0]           cnt_q, cnt_d;
	logic                  reg_reset_q;
	localparam logic [11:0] RST_LIM = 12'(hprx_pkg::RST_MIN_CYC);
	wire                   cnt_done = (cnt_q >= RST_LIM);
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			HPRX_IDLE: begin
				cnt_d = 12'h000;
				if (!i_hw_reset_n) begin
					st_d = HPRX_COUNT;
				end
			end
			HPRX_COUNT: begin
				if (i_hw_reset_n) begin
					st_d = HPRX_IDLE;
				end else if (cnt_done) begin
					st_d = HPRX_FIRED;
				end else begin
					cnt_d = cnt_q + 12'h001;
				end
			end
			HPRX_FIRED: begin
				if (i_hw_reset_n) begin
					st_d = HPRX_IDLE;
				end
			end
		endcase
	end
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q        <= HPRX_IDLE;
			cnt_q       <= 12'h000;
			reg_reset_q <= 1'b1;
		end else begin
			st_q        <= st_d;
			cnt_q       <= cnt_d;
			reg_reset_q <= (st_d == HPRX_FIRED);
		end
	end
	assign o_reg_reset = reg_reset_q;

	// host type decode; undefined codes flagged
	logic [1:0] mode_q;
	logic       bad_q;
	wire  [1:0] mode_w = (i_host_type_select == hprx_pkg::HT_ASYNC_B) ? 2'h1 :
		(i_host_type_select == hprx_pkg::HT_SYNC) ? 2'h2 : 2'h0;
	wire        bad_w  = !(i_host_type_select == hprx_pkg::HT_ASYNC_A ||
		i_host_type_select == hprx_pkg::HT_ASYNC_B ||
		i_host_type_select == hprx_pkg::HT_SYNC);
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= 2'h0;
			bad_q  <= 1'b0;
		end else begin
			mode_q <= mode_w;
			bad_q  <= bad_w;
		end
	end
	assign o_host_mode     = mode_q;
	assign o_host_type_bad = bad_q;

	// cascade decode
	logic       self_w, rsvd_w;
	logic [4:0] casc_w;
	hprx_casc_dec u_dec (
		.i_upper (i_addr[hprx_pkg::SEL_MSB:hprx_pkg::SEL_LSB]),
		.i_cs_n  (i_cs_n),
		.o_self  (self_w),
		.o_casc  (casc_w),
		.o_rsvd  ()
	);
	logic       self_q;
	logic [4:0] casc_n_q;
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			self_q   <= 1'b0;
			casc_n_q <= hprx_pkg::CASC_IDLE_N;
		end else begin
			self_q   <= self_w;
			casc_n_q <= ~casc_w;
		end
	end
	assign o_self_sel = self_q;
	assign o_cascade_select_out_1_n = casc_n_q[0];
	assign o_cascade_select_out_2_n = casc_n_q[1];
	assign o_cascade_select_out_3_n = casc_n_q[2];
	assign o_cascade_select_out_4_n = casc_n_q[3];
	assign o_cascade_select_out_5_n = casc_n_q[4];

	// data bus: drive only on a selected read, sample on a selected write
	logic [7:0] dout_q, wdat_q;
	logic       oe_n_q, wval_q;
	wire        drive_w = i_rd_active && self_w;
	wire        wtake_w = i_wr_strobe && self_w && !i_rd_active;
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dout_q <= 8'h00;
			oe_n_q <= 1'b1;
			wdat_q <= 8'h00;
			wval_q <= 1'b0;
		end else begin
			dout_q <= drive_w ? i_rd_data : 8'h00;
			oe_n_q <= !drive_w;
			wval_q <= wtake_w;
			if (wtake_w) begin
				wdat_q <= i_data;
			end
		end
	end
	assign o_data      = dout_q;
	assign o_data_oe_n = oe_n_q;
	assign o_wr_data   = wdat_q;
	assign o_wr_valid  = wval_q;

	// receiver power and termination; qualified reset also drops them,
	// since the register bits behind them return to defaults then
	wire [13:0] pwr_w  = i_receiver_power_pin ? i_rx_en_bits : 14'h0000;
	wire [13:0] term_w = i_termination_source_select ?
		{14{i_receive_termination_pin}} : i_term_bits;
	logic [13:0] pwr_q, term_q;
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pwr_q  <= hprx_pkg::RX_EN_RST;
			term_q <= hprx_pkg::TERM_RST;
		end else begin
			pwr_q  <= reg_reset_q ? hprx_pkg::RX_EN_RST : pwr_w;
			term_q <= reg_reset_q ? hprx_pkg::TERM_RST : term_w;
		end
	end
	assign o_rx_power = pwr_q;
	assign o_rx_term  = term_q;

	// assertions
	a_rx_forced_off: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		!i_receiver_power_pin ##1 1 |-> o_rx_power == 14'h0000)
		else $error("receivers on while enable pin low");
	a_rx_follow: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_receiver_power_pin && !reg_reset_q) |=> o_rx_power == $past(i_rx_en_bits))
		else $error("receiver power not following bits");
	a_term_pin: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_termination_source_select && !reg_reset_q) |=>
		o_rx_term == {14{$past(i_receive_termination_pin)}})
		else $error("termination not following pin");
	a_term_bits: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(!i_termination_source_select && !reg_reset_q) |=> o_rx_term == $past(i_term_bits))
		else $error("termination not following bits");
	a_casc_idle: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		i_cs_n |=> casc_n_q == 5'h1f)
		else $error("cascade select without chip select");
	a_casc_all: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(!i_cs_n && i_addr[10:8] == 3'h7) |=> casc_n_q == 5'h00 && self_q)
		else $error("all-select decode wrong");
	a_casc_one: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(!i_cs_n && i_addr[10:8] == 3'h3) |=> casc_n_q == 5'h1b && !self_q)
		else $error("cascade 3 decode wrong");
	a_rst_short: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		$rose(i_hw_reset_n) ##1 !i_hw_reset_n [*8] |-> !reg_reset_q)
		else $error("reset fired on short pulse");
	a_bus_drive: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		!o_data_oe_n |-> $past(i_rd_active))
		else $error("bus driven outside a read");
	a_type_bad: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		i_host_type_select == 3'h2 |=> o_host_type_bad)
		else $error("undefined host type not flagged");
endmodule : hprx_top

// ---- tb/hprx_host_model.sv ----
// hprx_host_model: host side of the shared data bus
// assumes the device drives only while its oe_n is low
`timescale 1ns/10ps
module hprx_host_model (
	// clock and device drive
	input  wire logic       i_clk,
	input  wire logic       i_dev_oe_n,
	input  wire logic [7:0] i_dev_data,
	// host write byte
	input  wire logic       i_wr_en,
	input  wire logic [7:0] i_wr_byte,
	// resolved bus level
	output logic [7:0]      o_bus
);
	logic [7:0] last_q;
	// released bus shows the inverse of the last value, never a stale match
	assign o_bus = !i_dev_oe_n ? i_dev_data : (i_wr_en ? i_wr_byte : ~last_q);
	// remember the last resolved level
	always_ff @(posedge i_clk) last_q <= o_bus;
endmodule : hprx_host_model

// ---- tb/hprx_top_tb.sv ----
// hprx_top_tb: self-checking bench for host port pin control
// assumes the host model resolves the data bus; other pins driven here
`timescale 1ns/10ps
module hprx_top_tb;
	logic        clk, nrst, cs_n, hwr_n, rd, wr, tsrc, pwr, tpin, w_en, oe_n, wv, bad, rr, self;
	logic [10:0] addr;
	logic [7:0]  rdd, wbyte, bus, od, wd;
	logic [2:0]  hts;
	logic [13:0] rxb, tbit, pw, tm;
	logic [1:0]  mode;
	logic [4:0]  cs;
	int          n_mismatch = 0;
	int          checks_done = 0;
	hprx_top i_hprx_top (.i_clk(clk), .i_nrst(nrst), .i_data(bus), .i_addr(addr),
		.i_cs_n(cs_n), .i_host_type_select(hts), .i_hw_reset_n(hwr_n),
		.i_rd_active(rd), .i_wr_strobe(wr), .i_rd_data(rdd), .i_rx_en_bits(rxb),
		.i_term_bits(tbit), .i_termination_source_select(tsrc),
		.i_receiver_power_pin(pwr), .i_receive_termination_pin(tpin), .o_data(od),
		.o_data_oe_n(oe_n), .o_wr_data(wd), .o_wr_valid(wv), .o_host_mode(mode),
		.o_host_type_bad(bad), .o_reg_reset(rr), .o_self_sel(self),
		.o_cascade_select_out_1_n(cs[0]), .o_cascade_select_out_2_n(cs[1]),
		.o_cascade_select_out_3_n(cs[2]), .o_cascade_select_out_4_n(cs[3]),
		.o_cascade_select_out_5_n(cs[4]), .o_rx_power(pw), .o_rx_term(tm));
	hprx_host_model i_hprx_host_model (.i_clk(clk), .i_dev_oe_n(oe_n), .i_dev_data(od),
		.i_wr_en(w_en), .i_wr_byte(wbyte), .o_bus(bus));
	// clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one edge to sample, one to let registered outputs settle
	task step;
		repeat (2) @(posedge clk);
		#1;
	endtask : step
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// every upper address code, with the host select on and off
	task t_decode;
		logic [4:0] e;
		for (int c = 0; c < 16; c++) begin
			e = 5'h1f;
			if (!c[3] && c[2:0] >= 1 && c[2:0] <= 5) e[c[2:0]-1] = 1'b0;
			if (!c[3] && c[2:0] == 7) e = 5'h00;
			@(posedge clk);
			cs_n <= c[3];
			addr <= {c[2:0], 8'h3c};
			step;
			chk(cs, e);
			chk(self, !c[3] && (c[2:0] == 0 || c[2:0] == 7));
		end
	endtask : t_decode
	// read drives the bus, write is captured, write without select refused
	task t_rdwr;
		@(posedge clk);
		cs_n <= 1'b0;
		addr <= 11'h012;
		rd <= 1'b1;
		step;
		chk(oe_n, 1'b0);
		chk(bus, rdd);
		// drive lingers one cycle after the read; host waits before writing
		@(posedge clk);
		rd <= 1'b0;
		step;
		chk({oe_n, wv}, {1'b1, 1'b0});
		@(posedge clk);
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
		chk({wv, wd, oe_n}, {1'b1, 8'hc3, 1'b1});
		@(posedge clk);
		cs_n  <= 1'b1;
		wr    <= 1'b1;
		wbyte <= 8'h3c;
		@(posedge clk);
		wr <= 1'b0;
		#1;
		chk({wv, wd, oe_n}, {1'b0, 8'hc3, 1'b1});
	endtask : t_rdwr
	// all eight host type codes
	task t_type;
		for (int c = 0; c < 8; c++) begin
			@(posedge clk);
			hts <= c[2:0];
			step;
			chk(mode, (c == 1) ? 2'h1 : ((c == 7) ? 2'h2 : 2'h0));
			chk(bad, c != 0 && c != 1 && c != 7);
		end
	endtask : t_type
	// receiver power and termination sources
	task t_rx;
		@(posedge clk);
		pwr <= 1'b1;
		tsrc <= 1'b0;
		step;
		chk({pw, tm}, {14'h2a55, 14'h1234});
		@(posedge clk);
		pwr <= 1'b0;
		tsrc <= 1'b1;
		step;
		chk({pw, tm}, 28'h0);
		@(posedge clk);
		tpin <= 1'b1;
		step;
		chk(tm, 14'h3fff);
	endtask : t_rx
	// short low is ignored, long low restores defaults
	task t_hwreset;
		@(posedge clk);
		pwr <= 1'b1;
		hwr_n <= 1'b0;
		repeat (2400) @(posedge clk);
		#1;
		chk(rr, 1'b0);
		repeat (200) @(posedge clk);
		#1;
		chk({rr, pw, tm}, {1'b1, 28'h0});
		@(posedge clk);
		hwr_n <= 1'b1;
		step;
		chk({rr, pw}, {1'b0, 14'h2a55});
		// short lows around a one-cycle high must not fire
		@(posedge clk);
		hwr_n <= 1'b0;
		repeat (20) @(posedge clk);
		hwr_n <= 1'b1;
		@(posedge clk);
		hwr_n <= 1'b0;
		repeat (20) @(posedge clk);
		hwr_n <= 1'b1;
		step;
		chk({rr, pw}, {1'b0, 14'h2a55});
	endtask : t_hwreset
	// watchdog, about five and a half times the expected run
	initial begin
		#60000;
		n_mismatch++;
		conclude();
	end
	// select, read, write, power pin and register bits asserted while reset holds outputs idle
	initial begin
		{nrst, cs_n, rd, wr, w_en, tsrc, tpin} = 7'h1c;
		{hwr_n, pwr, addr, hts} = {2'h3, 11'h7ff, 3'h0};
		{rdd, wbyte, rxb, tbit} = {8'h5a, 8'hc3, 14'h3fff, 14'h3fff};
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd   <= 1'b0;
		wr   <= 1'b0;
		{rxb, tbit} <= {14'h2a55, 14'h1234};
		// internal reset copy still low for two more edges
		#1;
		chk({oe_n, cs, rr, pw, tm}, {1'b1, 5'h1f, 1'b1, 28'h0});
		repeat (3) @(posedge clk);
		t_decode();
		t_rdwr();
		t_type();
		t_rx();
		t_hwreset();
		conclude();
	end
endmodule : hprx_top_tb
